// File: float_fixed_arith_flags.v
// arithmetic section: universal accumulator, save register, status flags
// Operation
// RL1 - z/g/l show accumulator result each instruction
// RL2 - compare sets flags only, nothing else changes
// RL3 - flag test gates jump, link, halt, execute
// RL4 - exponent out of field raises exponent fault
// RL5 - carry flag from magnitude carry, no fault
// RL6 - overflow flag for capacity and illegal operations
// RL7 - overflow sticky, cleared only by flag test
// RL8 - overflow is magnitude carry xor sign carry
// RL9 - results checked against range minus one to one
// RL10 - fixed or index fault: complete, overflow set
// RL11 - float add/sub/mul fault: correct, overflow reset
// RL12 - divide fault: meaningless sets, corrected resets overflow
// RL13 - float store rounded fault: corrected, overflow reset
// RL14 - integer store fault: complete, overflow set
// RL15 - double float uses upper, float and double ext
// RL16 - double ext holds product and dividend
// RL17 - save register keeps every accumulator grouping
// RL18 - single float loads whole word, upper+float ext
// RL19 - double load/store use two words plus ext
// RL20 - unnormalized variants skip post normalization
// RL21 - normalized ops align, operate, correct, normalize
// RL22 - decode ten operations across six classes
// RL23 - all operands two's complement
// RL24 - single float is upper word plus float ext
// RL25 - clear ops clear accumulator before operating
// RL26 - exponent fault request held until acknowledged
`include "float_fixed_arith_map.vh"

module float_fixed_arith_flags (
	input  wire        sys_clk_i,
	input  wire        nrst_i,
	input  wire        op_valid_i,
	input  wire [3:0]  op_code_i,
	input  wire [2:0]  op_class_i,
	input  wire        unnorm_i,
	input  wire        src_save_i,
	input  wire        dst_save_i,
	input  wire [31:0] mem_word_i,
	input  wire [31:0] mem_word2_i,
	input  wire [15:0] index_val_i,
	input  wire        test_valid_i,
	input  wire [4:0]  test_mask_i,
	input  wire [1:0]  test_act_i,
	input  wire        xfault_ack_i,
	output wire        done_o,
	output wire [15:0] upper_o,
	output wire [15:0] fixed_ext_reg_o,
	output wire [15:0] float_ext_reg_o,
	output wire [23:0] dbl_ext_reg_o,
	output wire [4:0]  flags_o,
	output wire        st_wr_o,
	output wire [31:0] st_data_o,
	output wire [31:0] st_data2_o,
	output wire        idx_wr_o,
	output wire [15:0] idx_data_o,
	output wire        take_o,
	output wire [1:0]  take_act_o,
	output wire        xfault_req_o
);

////////////////////////////////////////////////////////////////////////
// normalize shift count: redundant sign bits
function [5:0] lead;
	input [47:0] m;
	integer      i;
	reg          stop;
	begin
		lead = 6'h00;
		stop = 1'b0;
		for (i = 46; i >= 0; i = i - 1) begin
			if (!stop) begin
				if (m[i] == m[47])
					lead = lead + 6'h01;
				else
					stop = 1'b1;
			end
		end
	end
endfunction

////////////////////////////////////////////////////////////////////////
// state
reg [15:0] a_ff, fixed_ext_reg_ff, float_ext_reg_ff;
reg [23:0] dbl_ext_reg_ff;
reg [15:0] sv_a_ff, sv_fx_ff, sv_fl_ff;
reg [23:0] sv_dx_ff;
reg        z_ff, g_ff, l_ff, c_ff, v_ff;
reg        done_ff, st_wr_ff, idx_wr_ff, take_ff, xfault_ff;
reg [31:0] st_data_ff, st_data2_ff;
reg [15:0] idx_data_ff;
reg [1:0]  take_act_ff;

reg [15:0] nxt_a, nxt_fx, nxt_fl, nxt_sa, nxt_sx, nxt_sf, nxt_id;
reg [23:0] nxt_dx, nxt_sd;
reg        nxt_z, nxt_g, nxt_l, nxt_c, nxt_v, nxt_st, nxt_iw, nxt_xf;
reg [31:0] nxt_d1, nxt_d2;

////////////////////////////////////////////////////////////////////////
// decode
wire is_dbl = (op_class_i == `CL_DBL);
wire is_int = (op_class_i == `CL_INT);
wire is_ext = (op_class_i == `CL_EXT);
wire is_idx = (op_class_i == `CL_IDX);
wire is_fl  = (op_class_i == `CL_FLT) | is_dbl | is_int;
wire o_cl   = (op_code_i == `OP_CSUB) | (op_code_i == `OP_CADD) | (op_code_i == `OP_CDIV);
wire o_cmp  = (op_code_i == `OP_CMP);
wire o_neg  = (op_code_i == `OP_SUB) | (op_code_i == `OP_CSUB) | o_cmp;
wire o_add  = o_neg | (op_code_i == `OP_CADD) | (op_code_i == `OP_ADD);
wire o_mul  = (op_code_i == `OP_MUL);
wire o_div  = (op_code_i == `OP_DIV) | (op_code_i == `OP_CDIV);
wire o_rnd  = (op_code_i == `OP_STR);
wire o_st   = (op_code_i == `OP_ST) | o_rnd;
wire dbl_clear_add_op = is_dbl & (op_code_i == `OP_CADD);
wire dbl_clear_sub_op = is_dbl & (op_code_i == `OP_CSUB);
wire dbl_store_op     = is_dbl & o_st;

// operand views from memory or save register
wire [31:0] opw  = src_save_i ? (is_ext ? {sv_a_ff, sv_fx_ff} : {sv_a_ff, sv_fl_ff})
			: mem_word_i;
wire [31:0] opw2 = src_save_i ? {sv_dx_ff, 8'h00} : mem_word2_i;
wire [15:0] half = src_save_i ? sv_a_ff : mem_word_i[15:0];

////////////////////////////////////////////////////////////////////////
// datapath temporaries
reg signed [47:0] am, bm, r, dvd, q;
reg signed [9:0]  ae, be, e, sh;
reg signed [49:0] ax, bx, sm;
reg signed [95:0] fp;
reg        [48:0] dm, vm;
reg        [95:0] qn;
reg signed [31:0] iv, fa, fo, fr, fq;
reg        [24:0] rr;
reg        [15:0] hw;
reg        [31:0] lo;
reg        [32:0] tot, fdm, fvm;
reg signed [63:0] fp2;
reg        [63:0] fqn;
reg        [5:0]  n;
reg        rz, rs, setv, xf, cm;

always @* begin
	{nxt_a, nxt_fx, nxt_fl} = {a_ff, fixed_ext_reg_ff, float_ext_reg_ff};
	{nxt_dx, nxt_sd} = {dbl_ext_reg_ff, sv_dx_ff};
	{nxt_sa, nxt_sx, nxt_sf} = {sv_a_ff, sv_fx_ff, sv_fl_ff};
	{nxt_st, nxt_iw, nxt_id} = {2'h0, idx_data_ff};
	{nxt_d1, nxt_d2} = {st_data_ff, st_data2_ff};
	{nxt_z, nxt_g, nxt_l, nxt_c} = {z_ff, g_ff, l_ff, c_ff};
	{am, bm, r, dvd, q} = 240'h0;
	{ae, be, e, sh} = 40'h0;
	{ax, bx, sm} = 150'h0;
	{fp, qn} = 192'h0;
	{dm, vm} = 98'h0;
	{iv, fa, fo, fr, fq} = 160'h0;
	{rr, hw, lo, tot, fdm, fvm} = 172'h0;
	{fp2, fqn} = 128'h0;
	{n, rz, rs, setv, xf, cm} = 11'h000;
	if (op_valid_i && is_fl) begin // RL22
		// operand: whole word, integer half-word, or two words
		be = is_int ? `INT_EXP : {{2{opw[7]}}, opw[7:0]};
		bm = is_int ? {half, 32'h0} : (is_dbl ? {opw[31:8], opw2[31:8]} // RL18 RL19
			: {opw[31:8], 24'h0});
		am = o_cl ? 48'h0 : {a_ff, float_ext_reg_ff[15:8], // RL25
			(is_dbl ? dbl_ext_reg_ff : 24'h0)}; // RL15 RL24
		ae = o_cl ? be : {{2{float_ext_reg_ff[`EXP_MSB]}}, float_ext_reg_ff[7:0]};
		{rz, rs} = {(am == 48'h0), am[47]};
		if (o_st) begin
			if (is_int) begin
				sh = `INT_EXP - ae;
				iv = am[47:16];
				if (sh < 0)
					setv = 1'b1; // RL14
				else if (sh > 31)
					iv = iv >>> 31;
				else
					iv = iv >>> sh[4:0];
				hw = iv[31:16] + {15'h0, o_rnd & iv[15]};
				if (!iv[31] && hw[15])
					setv = 1'b1; // RL14
				nxt_d1 = {16'h0, hw};
			end else if (dbl_store_op) begin
				nxt_d1 = {a_ff, float_ext_reg_ff};
				nxt_d2 = {dbl_ext_reg_ff, float_ext_reg_ff[7:0] - `DBL_EXP_STEP}; // RL19
			end else if (o_rnd) begin
				rr = {am[47], am[47:24]} + {24'h0, dbl_ext_reg_ff[23]};
				e = ae;
				if (rr[24] != rr[23]) begin
					rr = {rr[24], rr[24:1]}; // RL13
					e = ae + 10'h1;
				end
				xf = (e > 127);
				nxt_d1 = {rr[23:0], e[7:0]};
			end else
				nxt_d1 = {a_ff, float_ext_reg_ff};
		end else begin
			if (o_add) begin
				ax = {{2{am[47]}}, am};
				bx = {{2{bm[47]}}, bm};
				if (o_neg)
					bx = -bx;
				if (ae >= be) begin // RL21
					bx = bx >>> (ae - be);
					e = ae;
				end else begin
					ax = ax >>> (be - ae);
					e = be;
				end
				sm = ax + bx;
				r = sm[47:0];
				if (sm[48] != sm[47]) begin // RL9
					r = sm[48:1]; // RL11
					e = e + 10'h1;
				end
			end else if (o_mul) begin
				fp = am * bm;
				r = fp[94:47]; // RL16
				e = ae + be;
				if (fp[95] != fp[94]) begin
					r = fp[95:48]; // RL11
					e = e + 10'h1;
				end
			end else begin
				dvd = (is_dbl | o_cl) ? am : {am[47:24], dbl_ext_reg_ff}; // RL16
				dm = dvd[47] ? -{dvd[47], dvd} : {dvd[47], dvd};
				vm = bm[47] ? -{bm[47], bm} : {bm[47], bm};
				e = ae - be;
				if (vm == 49'h0 || dm >= {vm[47:0], 1'b0})
					setv = 1'b1; // RL12
				else if (dm >= vm) begin
					dm = {1'b0, dm[48:1]}; // RL12
					e = e + 10'h1;
				end
				if (vm != 49'h0)
					qn = {dm[48:0], 47'h0} / {47'h0, vm};
				q = qn[47:0];
				r = (dvd[47] ^ bm[47]) ? -q : q;
			end
			if (!unnorm_i && r != 48'h0) begin // RL20
				n = lead(r); // RL21
				r = r <<< n;
				e = e - {4'h0, n};
			end
			{rz, rs} = {(r == 48'h0), r[47]};
			if (o_cmp) begin
				{rz, rs} = {(sm == 50'h0), sm[49]}; // RL2
			end else begin
				xf = (e > 127) || (e < -128); // RL4
				nxt_a = r[47:32];
				nxt_fl = {r[31:24], e[7:0]};
				if (is_dbl | o_mul | o_div)
					nxt_dx = r[23:0]; // RL15 RL16
			end
		end
	end else if (op_valid_i) begin
		// fixed, extended and index work left-justified in 32 bits
		fa = o_cl ? 32'h0 : (is_idx ? {index_val_i, 16'h0} // RL25
			: (is_ext ? {a_ff, fixed_ext_reg_ff} : {a_ff, 16'h0}));
		fo = is_ext ? opw : {half, 16'h0};
		{rz, rs} = {(fa == 32'h0), fa[31]};
		if (o_add) begin
			lo = {1'b0, fa[30:0]} + {1'b0, (o_neg ? ~fo[30:0] : fo[30:0])}
				+ {31'h0, o_neg};
			tot = {1'b0, fa} + {1'b0, (o_neg ? ~fo : fo)} + {32'h0, o_neg}; // RL23
			cm = lo[31];
			setv = cm ^ tot[32]; // RL8
			fr = tot[31:0];
			rs = fr[31] ^ (setv & o_cmp);
		end else if (o_mul) begin
			fp2 = fa * fo;
			fr = fp2[62:31];
			setv = fp2[63] ^ fp2[62]; // RL6
			rs = fr[31];
		end else if (o_div) begin
			fq = o_cl ? 32'h0 : (is_idx ? {index_val_i, 16'h0}
				: {a_ff, fixed_ext_reg_ff});
			fdm = fq[31] ? -{fq[31], fq} : {fq[31], fq};
			fvm = fo[31] ? -{fo[31], fo} : {fo[31], fo};
			setv = (fdm >= fvm); // RL6 RL10
			if (fvm != 33'h0)
				fqn = {fdm[31:0], 32'h0} / {31'h0, fvm};
			fr = (fq[31] ^ fo[31]) ? -fqn[32:1] : fqn[32:1];
			rs = fr[31];
		end else if (o_st) begin
			fr = fa;
			if (is_ext)
				nxt_d1 = {a_ff, fixed_ext_reg_ff};
			else if (is_idx)
				nxt_d1 = {16'h0, index_val_i};
			else begin
				hw = a_ff + {15'h0, o_rnd & fixed_ext_reg_ff[15]};
				setv = !a_ff[15] & hw[15]; // RL10
				nxt_d1 = {16'h0, hw};
			end
		end
		if (!o_st) begin
			rz = (fr == 32'h0);
			if (o_cmp)
				rz = (fr == 32'h0); // RL2
			else if (is_idx) begin
				nxt_iw = 1'b1;
				nxt_id = fr[31:16];
			end else if (is_ext) begin
				nxt_a = fr[31:16];
				nxt_fx = fr[15:0];
			end else begin
				nxt_a = fr[31:16];
				if (o_mul | o_div)
					nxt_fx = fr[15:0];
			end
		end
	end
	if (op_valid_i) begin
		nxt_c = cm; // RL5
		nxt_z = rz; // RL1
		nxt_g = !rz & !rs;
		nxt_l = rs;
		if (o_st && dst_save_i) begin
			nxt_sa = a_ff; // RL17
			nxt_sx = fixed_ext_reg_ff;
			nxt_sf = float_ext_reg_ff;
			nxt_sd = dbl_ext_reg_ff;
		end else if (o_st)
			nxt_st = 1'b1;
	end
	// sticky overflow: a set in the same cycle beats the test clear
	nxt_v = (v_ff & !test_valid_i) | (op_valid_i & setv); // RL6 RL7
	nxt_xf = (xfault_ff & !xfault_ack_i) | (op_valid_i & xf); // RL26
end

////////////////////////////////////////////////////////////////////////
// registers
always @(posedge sys_clk_i or negedge nrst_i) begin
	if (!nrst_i) begin
		{a_ff, fixed_ext_reg_ff, float_ext_reg_ff} <= {3{`ACC_RST}};
		{sv_a_ff, sv_fx_ff, sv_fl_ff, idx_data_ff} <= {4{`ACC_RST}};
		{dbl_ext_reg_ff, sv_dx_ff} <= {2{`DX_RST}};
		{st_data_ff, st_data2_ff} <= {2{`WORD_RST}};
		{z_ff, g_ff, l_ff, c_ff, v_ff} <= 5'h00;
		{done_ff, st_wr_ff, idx_wr_ff, take_ff, xfault_ff} <= 5'h00;
		take_act_ff <= `ACT_JUMP;
	end else begin
		{a_ff, fixed_ext_reg_ff, float_ext_reg_ff} <= {nxt_a, nxt_fx, nxt_fl};
		{sv_a_ff, sv_fx_ff, sv_fl_ff, sv_dx_ff} <= {nxt_sa, nxt_sx, nxt_sf, nxt_sd};
		{dbl_ext_reg_ff, idx_data_ff} <= {nxt_dx, nxt_id};
		{st_data_ff, st_data2_ff, st_wr_ff} <= {nxt_d1, nxt_d2, nxt_st};
		{z_ff, g_ff, l_ff, c_ff, v_ff} <= {nxt_z, nxt_g, nxt_l, nxt_c, nxt_v};
		{done_ff, idx_wr_ff, xfault_ff} <= {op_valid_i, nxt_iw, nxt_xf};
		take_ff <= test_valid_i & |(test_mask_i & flags_o); // RL3
		take_act_ff <= test_act_i;
	end
end

////////////////////////////////////////////////////////////////////////
// outputs
assign {done_o, st_wr_o, idx_wr_o} = {done_ff, st_wr_ff, idx_wr_ff};
assign {take_o, take_act_o, xfault_req_o} = {take_ff, take_act_ff, xfault_ff};
assign {upper_o, fixed_ext_reg_o, float_ext_reg_o} = {a_ff, fixed_ext_reg_ff, float_ext_reg_ff};
assign {st_data_o, st_data2_o} = {st_data_ff, st_data2_ff};
assign dbl_ext_reg_o = dbl_ext_reg_ff;
assign flags_o = {z_ff, g_ff, l_ff, c_ff, v_ff};
assign idx_data_o = idx_data_ff;

endmodule

// File: float_fixed_arith_map.vh
// opcode, class, field and flag constants for the arithmetic section
`ifndef FLOAT_FIXED_ARITH_MAP_VH
`define FLOAT_FIXED_ARITH_MAP_VH

// basic operations
`define OP_SUB      4'h0
`define OP_CSUB     4'h1
`define OP_CADD     4'h2
`define OP_ADD      4'h3
`define OP_CMP      4'h4
`define OP_MUL      4'h5
`define OP_ST       4'h6
`define OP_STR      4'h7
`define OP_DIV      4'h8
`define OP_CDIV     4'h9

// operand classes
`define CL_FLT      3'h0
`define CL_FIX      3'h1
`define CL_DBL      3'h2
`define CL_EXT      3'h3
`define CL_INT      3'h4
`define CL_IDX      3'h5

// exponent field, low byte of the combined word
`define EXP_MSB     7
`define EXP_MAX     10'h07f
`define EXP_MIN     10'h380
`define INT_EXP     10'h00f
`define DBL_EXP_STEP 8'h17

// flag test actions
`define ACT_JUMP    2'h0
`define ACT_LINK    2'h1
`define ACT_HALT    2'h2
`define ACT_EXEC    2'h3

// flag vector positions
`define F_Z         4
`define F_G         3
`define F_L         2
`define F_C         1
`define F_V         0

// reset values
`define ACC_RST     16'h0000
`define DX_RST      24'h000000
`define WORD_RST    32'h00000000

`endif

// File: arith_flags_checker_asserts.sv
// assertion checker for the arithmetic section ports
`include "float_fixed_arith_map.vh"
module arith_flags_checker (
	input wire logic        sys_clk_i,
	input wire logic        nrst_i,
	input wire logic        op_valid_i,
	input wire logic [3:0]  op_code_i,
	input wire logic [2:0]  op_class_i,
	input wire logic        test_valid_i,
	input wire logic [4:0]  test_mask_i,
	input wire logic [1:0]  test_act_i,
	input wire logic        xfault_ack_i,
	input wire logic        done_o,
	input wire logic [15:0] upper_o,
	input wire logic [4:0]  flags_o,
	input wire logic        take_o,
	input wire logic [1:0]  take_act_o,
	input wire logic        xfault_req_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	////////////////////////////////////////////////////////////////
	a_done_after_op: assert property (op_valid_i |=> done_o)
		else $error("done missing after instruction");
	a_done_has_cause: assert property (done_o |-> $past(op_valid_i))
		else $error("done without instruction");
	a_take_when_set: assert property (test_valid_i && |(test_mask_i & flags_o)
		|=> take_o && take_act_o == $past(test_act_i)) else $error("test not taken");
	a_no_take_clear: assert property (test_valid_i && !(|(test_mask_i & flags_o))
		|=> !take_o) else $error("test taken wrongly");
	a_v_sticky: assert property (flags_o[`F_V] && !test_valid_i |=> flags_o[`F_V])
		else $error("overflow flag dropped");
	a_v_test_clears: assert property (test_valid_i && !op_valid_i |=> !flags_o[`F_V])
		else $error("overflow flag not cleared");
	a_xfault_held: assert property (xfault_req_o && !xfault_ack_i |=> xfault_req_o)
		else $error("fault request dropped");
	a_xfault_released: assert property (xfault_req_o && xfault_ack_i && !op_valid_i
		|=> !xfault_req_o) else $error("fault request stuck");
	a_cmp_keeps_acc: assert property (op_valid_i && op_code_i == `OP_CMP
		|=> $stable(upper_o)) else $error("compare changed accumulator");
	a_zero_flag: assert property (done_o && $past(op_class_i) == `CL_FIX
		&& $past(op_code_i) <= `OP_ADD |-> flags_o[`F_Z] == (upper_o == 16'h0000))
		else $error("zero flag wrong");
	c_take: cover property (take_o);
	c_ack: cover property (xfault_req_o && xfault_ack_i);
	c_ovf: cover property (done_o && flags_o[`F_V]);
endmodule
bind float_fixed_arith_flags arith_flags_checker i_chk (
	.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .op_valid_i(op_valid_i),
	.op_code_i(op_code_i), .op_class_i(op_class_i), .test_valid_i(test_valid_i),
	.test_mask_i(test_mask_i), .test_act_i(test_act_i), .xfault_ack_i(xfault_ack_i),
	.done_o(done_o), .upper_o(upper_o), .flags_o(flags_o), .take_o(take_o),
	.take_act_o(take_act_o), .xfault_req_o(xfault_req_o)
);

// File: arith_far_side_model.sv
// index register and store write-back model
module arith_far_side_model #(
	parameter logic [15:0] IDX_INIT = 16'h0010
) (
	input  wire logic        sys_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        idx_wr_i,
	input  wire logic [15:0] idx_data_i,
	input  wire logic        st_wr_i,
	input  wire logic [31:0] st_data_i,
	input  wire logic [31:0] st_data2_i,
	output wire logic [15:0] index_val_o,
	output wire logic [31:0] word_o,
	output wire logic [31:0] word2_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] index_ff;
	logic [31:0] word_ff;
	logic [31:0] word2_ff;
	assign index_val_o = index_ff;
	assign word_o = word_ff;
	assign word2_o = word2_ff;
	always @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			index_ff <= IDX_INIT;
			word_ff <= 32'h00000000;
			word2_ff <= 32'h00000000;
		end else begin
			if (idx_wr_i) index_ff <= idx_data_i;
			if (st_wr_i) begin
				word_ff <= st_data_i;
				word2_ff <= st_data2_i;
			end
		end
	end
endmodule

// File: float_fixed_arith_flags_tb_top.sv
// self-checking bench for the arithmetic section
`include "float_fixed_arith_map.vh"
module float_fixed_arith_flags_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [3:0] op; logic [15:0] v; logic [15:0] acc; logic [4:0] fl, m;} row_t;
	logic        sys_clk_i, nrst_i, op_valid_i, unnorm_i, src_save_i, dst_save_i;
	logic        test_valid_i, xfault_ack_i;
	logic [3:0]  op_code_i;
	logic [2:0]  op_class_i;
	logic [31:0] mem_word_i, mem_word2_i;
	logic [4:0]  test_mask_i;
	logic [1:0]  test_act_i;
	wire         done_o, st_wr_o, idx_wr_o, take_o, xfault_req_o;
	wire  [15:0] upper_o, fx_w, fl_w, idx_data_o, index_val_i;
	wire  [23:0] dbl_ext_reg_o;
	wire  [4:0]  flags_o;
	wire  [1:0]  take_act_o;
	wire  [31:0] st_data_o, st_data2_o, word_w, word2_w;
	int          bad_count, comparisons;
	row_t        rows [11] = '{'{`OP_CADD, 16'h1234, 16'h1234, 5'h08, 5'h1f},
		'{`OP_ADD, 16'h0001, 16'h1235, 5'h08, 5'h1f}, '{`OP_SUB, 16'h1235, 16'h0000, 5'h10, 5'h1d},
		'{`OP_CSUB, 16'h0001, 16'hffff, 5'h04, 5'h1d}, '{`OP_ADD, 16'h0001, 16'h0000, 5'h12, 5'h1f},
		'{`OP_CADD, 16'h4000, 16'h4000, 5'h08, 5'h1f}, '{`OP_ADD, 16'h4000, 16'h8000, 5'h07, 5'h1f},
		'{`OP_CADD, 16'h0005, 16'h0005, 5'h09, 5'h1f}, '{`OP_CMP, 16'h0003, 16'h0005, 5'h09, 5'h1d},
		'{`OP_CMP, 16'h0005, 16'h0005, 5'h11, 5'h1d}, '{`OP_CMP, 16'h0007, 16'h0005, 5'h05, 5'h1d}};
	float_fixed_arith_flags i_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
		.op_valid_i(op_valid_i), .op_code_i(op_code_i), .op_class_i(op_class_i),
		.unnorm_i(unnorm_i), .src_save_i(src_save_i), .dst_save_i(dst_save_i),
		.mem_word_i(mem_word_i), .mem_word2_i(mem_word2_i), .index_val_i(index_val_i),
		.test_valid_i(test_valid_i), .test_mask_i(test_mask_i), .test_act_i(test_act_i),
		.xfault_ack_i(xfault_ack_i), .done_o(done_o), .upper_o(upper_o),
		.fixed_ext_reg_o(fx_w), .float_ext_reg_o(fl_w), .dbl_ext_reg_o(dbl_ext_reg_o),
		.flags_o(flags_o), .st_wr_o(st_wr_o), .st_data_o(st_data_o), .st_data2_o(st_data2_o),
		.idx_wr_o(idx_wr_o), .idx_data_o(idx_data_o), .take_o(take_o),
		.take_act_o(take_act_o), .xfault_req_o(xfault_req_o));
	arith_far_side_model i_far (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .idx_wr_i(idx_wr_o),
		.idx_data_i(idx_data_o), .st_wr_i(st_wr_o), .st_data_i(st_data_o),
		.st_data2_i(st_data2_o), .index_val_o(index_val_i), .word_o(word_w), .word2_o(word2_w));
	////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			bad_count++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task print_verdict;
		$display("mismatches %0d, comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task op(input logic [3:0] c, input logic [2:0] k, input logic [31:0] w, w2,
		input logic u, s, d);
		@(negedge sys_clk_i);
		{op_code_i, op_class_i, mem_word_i, mem_word2_i} = {c, k, w, w2};
		{unnorm_i, src_save_i, dst_save_i, op_valid_i} = {u, s, d, 1'b1};
		@(negedge sys_clk_i);
		op_valid_i = 1'b0;
		check(32'(done_o), 32'h1);
	endtask
	task ftest(input logic [4:0] m, input logic [1:0] a, input logic t);
		@(negedge sys_clk_i);
		{test_mask_i, test_act_i, test_valid_i} = {m, a, 1'b1};
		@(negedge sys_clk_i);
		test_valid_i = 1'b0;
		check(32'(take_o), 32'(t));
		if (t) check(32'(take_act_o), 32'(a));
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		#(50 * 4000);
		bad_count++;
		print_verdict;
	end
	initial begin
		{nrst_i, op_valid_i, unnorm_i, src_save_i, dst_save_i, test_valid_i} = 6'h00;
		{xfault_ack_i, op_code_i, op_class_i, test_mask_i, test_act_i} = 15'h0000;
		{mem_word_i, mem_word2_i} = 64'h0;
		repeat (20) @(negedge sys_clk_i);
		check({upper_o, 11'h000, flags_o}, 32'h0);
		check(32'(xfault_req_o), 32'h0);
		nrst_i = 1'b1;
		foreach (rows[i]) begin
			op(rows[i].op, `CL_FIX, 32'(rows[i].v), 32'h0, 1'b0, 1'b0, 1'b0);
			check(32'(upper_o), 32'(rows[i].acc));
			check(32'(flags_o & rows[i].m), 32'(rows[i].fl & rows[i].m));
		end
		for (int a = 0; a < 4; a++) ftest(a == 0 ? 5'h01 : 5'h04, 2'(a), 1'b1);
		check(32'(flags_o[`F_V]), 32'h0);
		ftest(5'h01, 2'h0, 1'b0);
		op(`OP_ST, `CL_FIX, 32'h0, 32'h0, 1'b0, 1'b0, 1'b0);
		check({st_data_o[15:0], 15'h0, st_wr_o}, 32'h00050001);
		op(`OP_ST, `CL_FIX, 32'h0, 32'h0, 1'b0, 1'b0, 1'b1);
		check(32'(st_wr_o), 32'h0);
		op(`OP_CADD, `CL_FIX, 32'h0, 32'h0, 1'b0, 1'b0, 1'b0);
		op(`OP_CADD, `CL_FIX, 32'h0, 32'h0, 1'b0, 1'b1, 1'b0);
		check(32'(upper_o), 32'h5);
		op(`OP_DIV, `CL_FIX, 32'h10, 32'h0, 1'b0, 1'b0, 1'b0);
		check({upper_o, fx_w}, 32'h28000000);
		op(`OP_DIV, `CL_FIX, 32'h1, 32'h0, 1'b0, 1'b0, 1'b0);
		check(32'(flags_o[`F_V]), 32'h1);
		op(`OP_ADD, `CL_IDX, 32'h3, 32'h0, 1'b0, 1'b0, 1'b0);
		check({idx_data_o, 15'h0, idx_wr_o}, 32'h00130001);
		@(negedge sys_clk_i);
		check(32'(index_val_i), 32'h13);
		op(`OP_CADD, `CL_EXT, 32'h12345678, 32'h0, 1'b0, 1'b0, 1'b0);
		check({upper_o, fx_w}, 32'h12345678);
		op(`OP_CADD, `CL_FLT, 32'h4000007f, 32'h0, 1'b1, 1'b0, 1'b0);
		check({upper_o, fl_w}, 32'h4000007f);
		op(`OP_MUL, `CL_FLT, 32'h4000007f, 32'h0, 1'b0, 1'b0, 1'b0);
		check(32'(xfault_req_o), 32'h1);
		repeat (3) @(negedge sys_clk_i);
		check(32'(xfault_req_o), 32'h1);
		xfault_ack_i = 1'b1;
		@(negedge sys_clk_i);
		xfault_ack_i = 1'b0;
		check(32'(xfault_req_o), 32'h0);
		op(`OP_CADD, `CL_DBL, 32'h40000020, 32'h12345600, 1'b1, 1'b0, 1'b0);
		check(32'(dbl_ext_reg_o), 32'h123456);
		op(`OP_ST, `CL_DBL, 32'h0, 32'h0, 1'b0, 1'b0, 1'b0);
		@(negedge sys_clk_i);
		check(word_w, 32'h40000020);
		check(word2_w, 32'h12345609);
		print_verdict;
	end
endmodule
